// [include/pcfg_pkg.sv]
/*
 * Constants and carriers for the port configuration and keypad wake block.
 * Assumes a single CPU clock and a plain register port with byte data.
 */
package pcfg_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [7:0] OFS_P2_MODE = 8'hA4;
    localparam logic [7:0] OFS_P0_SEL_A = 8'h84;
    localparam logic [7:0] OFS_P0_SEL_B = 8'h85;
    localparam logic [7:0] OFS_P1_SEL_A = 8'h91;
    localparam logic [7:0] OFS_P1_SEL_B = 8'h92;
    localparam logic [7:0] OFS_P2_SEL_B = 8'hA5;
    localparam logic [7:0] OFS_P0_LATCH = 8'h80;
    localparam logic [7:0] OFS_P1_LATCH = 8'h90;
    localparam logic [7:0] OFS_P2_LATCH = 8'hA0;
    localparam logic [7:0] OFS_KEY_MASK = 8'h86;
    localparam logic [7:0] OFS_AUX_ONE = 8'hA2;
    localparam logic [7:0] OFS_CORE_CTL = 8'h87;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int P2S_BIT = 7;
    localparam int P1S_BIT = 6;
    localparam int P0S_BIT = 5;
    localparam int CLKOE_BIT = 4;
    localparam int TIMER1_TOGGLE_OUTPUT_ENABLE_BIT = 3;
    localparam int TIMER0_TOGGLE_OUTPUT_ENABLE_BIT = 2;
    localparam int KFLAG_BIT = 1;
    localparam int KEN_BIT = 0;
    localparam int IDLE_BIT = 0;
    localparam int PDOWN_BIT = 1;

    // ****************************************
    // Reset values and timing
    // ****************************************
    localparam logic [7:0] P2_MODE_RST = 8'h00;
    localparam logic [7:0] ZERO_RST = 8'h00;
    localparam logic [7:0] ONES_RST = 8'hFF;
    localparam int CLK_HZ = 40_000_000;
    localparam int STRONG_CLKS = 2;
    localparam int STRONG_CYC = STRONG_CLKS * (CLK_HZ / CLK_HZ);

    typedef enum logic [1:0] {
        PCFG_QUASI = 2'b00,
        PCFG_PUSH = 2'b01,
        PCFG_INPUT = 2'b10,
        PCFG_ODRAIN = 2'b11
    } pcfg_mode_e;

    // Per-pin driver controls
    typedef struct packed {
        logic very_weak_up;
        logic weak_up;
        logic strong_up;
        logic pull_down;
    } pcfg_drv_s;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pcfg_req_s;

endpackage : pcfg_pkg

// [design/pcfg_port.sv]
/*
 * Three-port pin configuration with keypad wake.
 * Assumes pins are synchronous to clk_i; wire resolution is outside.
 */
// Function
// - Two bits select pin output mode
// - Quasi very weak pull-up follows latch one
// - Quasi weak pull-up needs latch and pin high
// - Strong pull-up two clocks on rising latch
// - Open drain: no pull-ups, pull-down on zero
// - Push-pull strong up on one, down on zero
// - Input-only drives nothing
// - Quasi-bidirectional is default mode
// - Port 1 bits 2,3 always open drain
// - Port 1 bit 5 input only with internal reset
// - Crystal option disables port 2 bits 0,1
// - Reset level from configuration bit
// - Per-port Schmitt select bits 7,6,5
// - Port 1 bits 2,3,5 always Schmitt
// - Clock output enable, RC or external only
// - Timer toggle outputs toggle on overflow
// - Port 2 bits 1,0 mode from two registers
// - Enabled port 0 low sets keypad flag
// - Keypad raises interrupt and wake
// - Mask bit n enables port 0 bit n
`timescale 1ns/10ps

module pcfg_port #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // Straps
    input wire logic port_reset_high_select_i,
    input wire logic internal_reset_sel_i,
    input wire logic crystal_osc_sel_i,
    input wire logic rc_or_ext_clk_sel_i,
    // Register port
    input wire pcfg_pkg::pcfg_req_s req_i,
    output logic [7:0] rdata_o,
    // Timer events and clock
    input wire logic timer0_overflow_i,
    input wire logic timer1_overflow_i,
    input wire logic cpu_clk_div_i,
    input wire logic keypad_irq_enable_i,
    // Pins: input level and drivers per port
    input wire logic [3*WIDTH-1:0] pin_i,
    output pcfg_pkg::pcfg_drv_s [3*WIDTH-1:0] drv_o,
    output logic [3*WIDTH-1:0] schmitt_o,
    output logic [3*WIDTH-1:0] in_valid_o,
    // Special pin functions
    output logic clock_out_o,
    output logic timer0_toggle_o,
    output logic timer1_toggle_o,
    output logic timer0_toggle_en_o,
    output logic timer1_toggle_en_o,
    // Keypad
    output logic keypad_irq_o,
    output logic wake_o
);

    // ****************************************
    // Registers
    // ****************************************
    logic [7:0] port2_mode_and_misc_enables;
    logic [3*WIDTH-1:0] port_mode_sel_a;
    logic [3*WIDTH-1:0] port_mode_sel_b;
    logic [3*WIDTH-1:0] latch;
    logic [3*WIDTH-1:0] latch_d;
    logic [WIDTH-1:0] keypad_enable_mask;
    logic keypad_event_flag;
    logic keypad_active;
    logic [1:0] power_mode;
    logic [1:0] strong_cnt [3*WIDTH];
    logic tog0;
    logic tog1;
    logic first_cycle;
    logic key_hit;

    function automatic logic [7:0] rd_mux(input logic [7:0] a);
        logic [7:0] r;
        r = pcfg_pkg::ZERO_RST;
        unique case (a)
            pcfg_pkg::OFS_P2_MODE: r = port2_mode_and_misc_enables;
            pcfg_pkg::OFS_P0_SEL_A: r = port_mode_sel_a[7:0];
            pcfg_pkg::OFS_P0_SEL_B: r = port_mode_sel_b[7:0];
            pcfg_pkg::OFS_P1_SEL_A: r = port_mode_sel_a[15:8];
            pcfg_pkg::OFS_P1_SEL_B: r = port_mode_sel_b[15:8];
            pcfg_pkg::OFS_P2_SEL_B: r = port_mode_sel_b[23:16];
            pcfg_pkg::OFS_P0_LATCH: r = pin_i[7:0];
            pcfg_pkg::OFS_P1_LATCH: r = pin_i[15:8];
            pcfg_pkg::OFS_P2_LATCH: r = pin_i[23:16];
            pcfg_pkg::OFS_KEY_MASK: r = keypad_enable_mask;
            pcfg_pkg::OFS_AUX_ONE: begin
                r[pcfg_pkg::KFLAG_BIT] = keypad_event_flag;
                r[pcfg_pkg::KEN_BIT] = keypad_active;
            end
            pcfg_pkg::OFS_CORE_CTL: r[1:0] = power_mode;
            default: r = pcfg_pkg::ZERO_RST;
        endcase
        return r;
    endfunction : rd_mux

    function automatic logic wr_hit(input logic [7:0] a);
        return req_i.wr && (req_i.addr == a);
    endfunction : wr_hit

    // ****************************************
    // Reset strap capture
    // ****************************************
    always_ff @(posedge clk_i) begin
        first_cycle <= !reset_n_i;
    end

    // ****************************************
    // Mode and latch registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            port2_mode_and_misc_enables <= pcfg_pkg::P2_MODE_RST;
            port_mode_sel_a <= '0;
            port_mode_sel_b <= '0;
        end else begin
            if (wr_hit(pcfg_pkg::OFS_P2_MODE))
                port2_mode_and_misc_enables <= req_i.wdata;
            if (wr_hit(pcfg_pkg::OFS_P0_SEL_A))
                port_mode_sel_a[7:0] <= req_i.wdata;
            if (wr_hit(pcfg_pkg::OFS_P0_SEL_B))
                port_mode_sel_b[7:0] <= req_i.wdata;
            if (wr_hit(pcfg_pkg::OFS_P1_SEL_A))
                port_mode_sel_a[15:8] <= req_i.wdata;
            if (wr_hit(pcfg_pkg::OFS_P1_SEL_B))
                port_mode_sel_b[15:8] <= req_i.wdata;
            if (wr_hit(pcfg_pkg::OFS_P2_SEL_B))
                port_mode_sel_b[23:16] <= req_i.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            latch <= '0;
        end else if (first_cycle) begin
            latch <= {3*WIDTH{port_reset_high_select_i}};
        end else begin
            if (wr_hit(pcfg_pkg::OFS_P0_LATCH))
                latch[7:0] <= req_i.wdata;
            if (wr_hit(pcfg_pkg::OFS_P1_LATCH))
                latch[15:8] <= req_i.wdata;
            if (wr_hit(pcfg_pkg::OFS_P2_LATCH))
                latch[23:16] <= req_i.wdata;
        end
        latch_d <= latch;
    end

    // ****************************************
    // Keypad flag and power state
    // ****************************************
    assign key_hit = keypad_active &&
        |(keypad_enable_mask & ~pin_i[WIDTH-1:0]);

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            keypad_enable_mask <= pcfg_pkg::ZERO_RST;
            keypad_active <= 1'b0;
            keypad_event_flag <= 1'b0;
            power_mode <= 2'b00;
        end else begin
            if (wr_hit(pcfg_pkg::OFS_KEY_MASK))
                keypad_enable_mask <= req_i.wdata;
            if (wr_hit(pcfg_pkg::OFS_AUX_ONE))
                keypad_active <= req_i.wdata[pcfg_pkg::KEN_BIT];
            // Set wins over a software clear
            if (key_hit)
                keypad_event_flag <= 1'b1;
            else if (wr_hit(pcfg_pkg::OFS_AUX_ONE))
                keypad_event_flag <=
                    req_i.wdata[pcfg_pkg::KFLAG_BIT];
            if (key_hit || keypad_event_flag)
                power_mode <= 2'b00;
            else if (wr_hit(pcfg_pkg::OFS_CORE_CTL))
                power_mode <= req_i.wdata[1:0];
        end
    end

    assign keypad_irq_o = keypad_event_flag && keypad_irq_enable_i;
    // Wake pulses while the low-power state is still held
    assign wake_o = (key_hit || keypad_event_flag) &&
        (power_mode != 2'b00);

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!reset_n_i)
            rdata_o <= pcfg_pkg::ZERO_RST;
        else if (req_i.rd)
            rdata_o <= rd_mux(req_i.addr);
        else
            rdata_o <= pcfg_pkg::ZERO_RST;
    end

    // ****************************************
    // Timer toggles and clock out
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            tog0 <= 1'b0;
            tog1 <= 1'b0;
        end else begin
            if (timer0_overflow_i)
                tog0 <= !tog0;
            if (timer1_overflow_i)
                tog1 <= !tog1;
        end
    end

    assign timer0_toggle_o = tog0;
    assign timer1_toggle_o = tog1;
    assign timer0_toggle_en_o =
        port2_mode_and_misc_enables[pcfg_pkg::TIMER0_TOGGLE_OUTPUT_ENABLE_BIT];
    assign timer1_toggle_en_o =
        port2_mode_and_misc_enables[pcfg_pkg::TIMER1_TOGGLE_OUTPUT_ENABLE_BIT];
    assign clock_out_o = cpu_clk_div_i && rc_or_ext_clk_sel_i &&
        port2_mode_and_misc_enables[pcfg_pkg::CLKOE_BIT];

    // ****************************************
    // Pin drivers
    // ****************************************
    for (genvar i = 0; i < 3*WIDTH; i++) begin : g_pin
        pcfg_pkg::pcfg_mode_e mode;
        logic fixed_od;
        logic dead;
        logic in_only;

        assign fixed_od = (i == WIDTH + 2) || (i == WIDTH + 3);
        assign in_only = (i == WIDTH + 5);
        assign dead = crystal_osc_sel_i &&
            (i == 2*WIDTH || i == 2*WIDTH + 1);

        always_comb begin
            if (fixed_od)
                mode = pcfg_pkg::PCFG_ODRAIN;
            else if (in_only || dead)
                mode = pcfg_pkg::PCFG_INPUT;
            else if (i >= 2*WIDTH && i < 2*WIDTH + 2)
                mode = pcfg_pkg::pcfg_mode_e'({
                    port2_mode_and_misc_enables[i - 2*WIDTH],
                    port_mode_sel_b[i]});
            else
                mode = pcfg_pkg::pcfg_mode_e'({port_mode_sel_a[i],
                    port_mode_sel_b[i]});
        end

        always_ff @(posedge clk_i) begin
            if (!reset_n_i)
                strong_cnt[i] <= 2'd0;
            else if (latch[i] && !latch_d[i] &&
                     mode == pcfg_pkg::PCFG_QUASI)
                strong_cnt[i] <= 2'(pcfg_pkg::STRONG_CYC);
            else if (strong_cnt[i] != 2'd0)
                strong_cnt[i] <= strong_cnt[i] - 2'd1;
        end

        always_comb begin
            drv_o[i] = '0;
            unique case (mode)
                pcfg_pkg::PCFG_QUASI: begin
                    drv_o[i].very_weak_up = latch[i];
                    drv_o[i].weak_up = latch[i] && pin_i[i];
                    drv_o[i].strong_up = strong_cnt[i] != 2'd0;
                    drv_o[i].pull_down = !latch[i];
                end
                pcfg_pkg::PCFG_PUSH: begin
                    drv_o[i].strong_up = latch[i];
                    drv_o[i].pull_down = !latch[i];
                end
                pcfg_pkg::PCFG_ODRAIN:
                    drv_o[i].pull_down = !latch[i];
                pcfg_pkg::PCFG_INPUT: drv_o[i] = '0;
            endcase
        end

        assign in_valid_o[i] = !dead && !(in_only && !internal_reset_sel_i);
        assign schmitt_o[i] = (fixed_od || in_only) ? 1'b1 :
            port2_mode_and_misc_enables[pcfg_pkg::P0S_BIT + i/WIDTH];
    end

    // ****************************************
    // Checks
    // ****************************************
    a_strong_two_clks: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        (strong_cnt[0] == 2'd2) |=> (strong_cnt[0] == 2'd1) ##1
        (strong_cnt[0] == 2'd0))
        else $error("strong pull-up length wrong");
    a_flag_sets: assert property (@(posedge clk_i)
        disable iff (!reset_n_i) key_hit |=> keypad_event_flag)
        else $error("keypad flag not set");
    a_flag_sticky: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        keypad_event_flag && !wr_hit(pcfg_pkg::OFS_AUX_ONE)
        |=> keypad_event_flag)
        else $error("keypad flag cleared by itself");
    a_od_no_pullup: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        !drv_o[WIDTH+2].weak_up && !drv_o[WIDTH+2].strong_up &&
        drv_o[WIDTH+2].pull_down == !latch[WIDTH+2])
        else $error("fixed open drain pin pulls up");
    a_quasi_weak: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        drv_o[0].weak_up |-> latch[0] && pin_i[0])
        else $error("weak pull-up without latch and pin");
    a_schmitt_fixed: assert property (@(posedge clk_i)
        disable iff (!reset_n_i) schmitt_o[WIDTH+5] && schmitt_o[WIDTH+3])
        else $error("fixed pin lost schmitt input");
    a_irq_follows: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        keypad_irq_o == (keypad_event_flag && keypad_irq_enable_i))
        else $error("keypad interrupt mismatch");
    a_crystal_dead: assert property (@(posedge clk_i)
        disable iff (!reset_n_i)
        crystal_osc_sel_i |-> drv_o[2*WIDTH] == '0 &&
        !in_valid_o[2*WIDTH+1])
        else $error("crystal pin still active");

endmodule : pcfg_port

// [verif/pcfg_pin_model.sv]
/*
 * Pin-side model: resolves pin levels from the driver controls and from
 * keypad switches that short a pin to ground.
 * Assumes pins are sampled synchronously to the CPU clock.
 */
`timescale 1ns/10ps

module pcfg_pin_model #(
    parameter int N = 24
) (
    // Clock
    input wire logic clk_i,
    // Driver controls and closed switches
    input wire pcfg_pkg::pcfg_drv_s [N-1:0] drv_i,
    input wire logic [N-1:0] key_low_i,
    // Resolved pin levels
    output logic [N-1:0] pin_o
);

    // ****************************************
    // Pin resolution
    // ****************************************
    initial pin_o = '0;

    // A floating pin wanders so a stale level cannot pass for a drive
    always @(posedge clk_i) begin
        for (int i = 0; i < N; i++) begin
            if (key_low_i[i] || drv_i[i].pull_down) begin
                pin_o[i] <= 1'b0;
            end else if (drv_i[i].very_weak_up || drv_i[i].weak_up
                         || drv_i[i].strong_up) begin
                pin_o[i] <= 1'b1;
            end else begin
                pin_o[i] <= ~pin_o[i];
            end
        end
    end

endmodule : pcfg_pin_model

// [verif/pcfg_port_tb_top.sv]
/*
 * Self-checking bench for the port configuration and keypad wake block.
 * Assumes pcfg_pkg and the pin model pcfg_pin_model.
 */
`timescale 1ns/10ps

module pcfg_port_tb_top;

    // ****************************************
    // Signals
    // ****************************************
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic xtal = 1'b0;
    logic irst = 1'b0;
    logic rcx = 1'b0;
    logic t0_ov = 1'b0;
    logic t1_ov = 1'b0;
    logic kirq_en = 1'b0;
    logic [23:0] key_low = '0;
    pcfg_pkg::pcfg_req_s req = '0;
    logic [7:0] rdata_o;
    logic [23:0] pin_i;
    pcfg_pkg::pcfg_drv_s [23:0] drv_o;
    logic [23:0] schmitt_o;
    logic [23:0] in_valid_o;
    logic clock_out_o;
    logic [1:0] tog;
    logic [1:0] tog_en;
    logic keypad_irq_o;
    logic wake_o;
    logic [31:0] seed = 32'h0000_003C;
    int fails = 0;
    int check_count = 0;
    int strong_cnt = 0;
    int wake_cnt = 0;
    logic [7:0] ofs_a [2] = '{pcfg_pkg::OFS_P0_SEL_A, pcfg_pkg::OFS_P1_SEL_A};
    logic [7:0] ofs_b [2] = '{pcfg_pkg::OFS_P0_SEL_B, pcfg_pkg::OFS_P1_SEL_B};
    logic [7:0] ofs_l [2] = '{pcfg_pkg::OFS_P0_LATCH, pcfg_pkg::OFS_P1_LATCH};

    pcfg_port pcfg_port_i (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .port_reset_high_select_i(1'b1),
        .internal_reset_sel_i(irst),
        .crystal_osc_sel_i(xtal),
        .rc_or_ext_clk_sel_i(rcx),
        .req_i(req),
        .rdata_o(rdata_o),
        .timer0_overflow_i(t0_ov),
        .timer1_overflow_i(t1_ov),
        .cpu_clk_div_i(1'b1),
        .keypad_irq_enable_i(kirq_en),
        .pin_i(pin_i),
        .drv_o(drv_o),
        .schmitt_o(schmitt_o),
        .in_valid_o(in_valid_o),
        .clock_out_o(clock_out_o),
        .timer0_toggle_o(tog[0]),
        .timer1_toggle_o(tog[1]),
        .timer0_toggle_en_o(tog_en[0]),
        .timer1_toggle_en_o(tog_en[1]),
        .keypad_irq_o(keypad_irq_o),
        .wake_o(wake_o)
    );

    pcfg_pin_model pcfg_pin_model_i (
        .clk_i(clk_i),
        .drv_i(drv_o),
        .key_low_i(key_low),
        .pin_o(pin_i)
    );

    always #12.5 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (drv_o[0].strong_up === 1'b1) strong_cnt++;
        if (wake_o === 1'b1) wake_cnt++;
    end

    // ****************************************
    // Helpers and expected driver model
    // ****************************************
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Returns {very_weak_up, weak_up, strong_up, pull_down} when settled
    function automatic logic [3:0] exp_drv(int m, logic l, logic p);
        case (m)
            0: return {l, l & p, 1'b0, ~l};
            1: return {2'b00, l, ~l};
            3: return {3'b000, ~l};
            default: return 4'h0;
        endcase
    endfunction : exp_drv

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req.addr <= a;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk_i);
        req.wr <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e,
                      input string n);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_i);
        req.rd <= 1'b0;
        #1;
        chk(n, e, rdata_o);
        @(posedge clk_i);
    endtask : rd

    task automatic chk_port(input int p, input logic [7:0] a, b, l);
        int m;
        int n;
        for (int i = 0; i < 8; i++) begin
            m = {a[i], b[i]};
            n = p * 8 + i;
            if (p == 1 && (i == 2 || i == 3)) m = 3;
            if (p == 1 && i == 5) m = 2;
            chk("drv", exp_drv(m, l[i], pin_i[n]), drv_o[n]);
        end
    endtask : chk_port

    task automatic print_verdict();
        if (fails == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #(25 * 20000);
        fails++;
        print_verdict();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] l;
        logic [7:0] v;
        logic [1:0] tg;
        logic [23:0] e24;
        int m;
        repeat (8) @(posedge clk_i);
        reset_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        #1;
        chk_port(0, 8'h00, 8'h00, 8'hFF);
        chk_port(1, 8'h00, 8'h00, 8'hFF);
        @(posedge clk_i);
        rd(pcfg_pkg::OFS_P2_MODE, 8'h00, "p2 mode reset");
        rd(pcfg_pkg::OFS_AUX_ONE, 8'h00, "aux reset");
        wr(8'hC0, 8'h55);
        rd(8'hC0, 8'h00, "unmapped");
        for (int k = 0; k < 12; k++) begin
            a = xs();
            b = xs();
            l = xs();
            key_low[15:0] <= xs();
            wr(ofs_a[k % 2], a);
            wr(ofs_b[k % 2], b);
            wr(ofs_l[k % 2], l);
            repeat (5) @(posedge clk_i);
            #1;
            chk_port(k % 2, a, b, l);
            @(posedge clk_i);
        end
        key_low <= '0;
        wr(pcfg_pkg::OFS_P0_SEL_A, 8'h00);
        wr(pcfg_pkg::OFS_P0_SEL_B, 8'h00);
        wr(pcfg_pkg::OFS_P0_LATCH, 8'h00);
        repeat (3) @(posedge clk_i);
        strong_cnt = 0;
        wr(pcfg_pkg::OFS_P0_LATCH, 8'hFF);
        repeat (6) @(posedge clk_i);
        chk("strong", pcfg_pkg::STRONG_CLKS, strong_cnt);
        for (int k = 0; k < 4; k++) begin
            v = (k == 0) ? 8'hFC : (k == 1) ? 8'h00 : xs();
            wr(pcfg_pkg::OFS_P2_MODE, v);
            rd(pcfg_pkg::OFS_P2_MODE, v, "p2 mode");
            #1;
            e24 = {{8{v[7]}}, {8{v[6]}} | 8'h2C, {8{v[5]}}};
            chk("schmitt", e24, schmitt_o);
            chk("toggle en", v[3:2], tog_en);
            @(posedge clk_i);
        end
        wr(pcfg_pkg::OFS_P2_MODE, 8'h1C);
        #1;
        tg = ~tog;
        @(posedge clk_i);
        t0_ov <= 1'b1;
        t1_ov <= 1'b1;
        @(posedge clk_i);
        t0_ov <= 1'b0;
        t1_ov <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        chk("toggle", tg, tog);
        chk("clock out", 0, clock_out_o);
        @(posedge clk_i);
        rcx <= 1'b1;
        xtal <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("clock out", 1, clock_out_o);
        chk("xtal valid", 0, in_valid_o[17:16]);
        chk("xtal drv", 0, {drv_o[17], drv_o[16]});
        chk("p15 valid", 0, in_valid_o[13]);
        @(posedge clk_i);
        xtal <= 1'b0;
        irst <= 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        chk("valid", 3'b111, {in_valid_o[17:16], in_valid_o[13]});
        @(posedge clk_i);
        m = xs() % 7;
        v = (xs() & 8'h7F) | (8'h01 << m);
        wr(pcfg_pkg::OFS_AUX_ONE, 8'h01);
        wr(pcfg_pkg::OFS_KEY_MASK, v);
        rd(pcfg_pkg::OFS_KEY_MASK, v, "mask");
        key_low[7] <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(pcfg_pkg::OFS_AUX_ONE, 8'h01, "flag off mask");
        key_low[7] <= 1'b0;
        wr(pcfg_pkg::OFS_CORE_CTL, 8'h01);
        wake_cnt = 0;
        key_low[m] <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(pcfg_pkg::OFS_AUX_ONE, 8'h03, "flag set");
        #1;
        chk("irq off", 0, keypad_irq_o);
        @(posedge clk_i);
        kirq_en <= 1'b1;
        key_low[m] <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1;
        chk("irq on", 1, keypad_irq_o);
        chk("wake", 1, wake_cnt != 0);
        @(posedge clk_i);
        rd(pcfg_pkg::OFS_CORE_CTL, 8'h00, "power ctl");
        rd(pcfg_pkg::OFS_AUX_ONE, 8'h03, "flag sticky");
        wr(pcfg_pkg::OFS_AUX_ONE, 8'h01);
        rd(pcfg_pkg::OFS_AUX_ONE, 8'h01, "flag clear");
        #1;
        chk("irq clear", 0, keypad_irq_o);
        print_verdict();
    end

endmodule : pcfg_port_tb_top
